// [logic/starter_alarm_monitor.v]
// Operation
// - overload alarm when thermal content reaches 90 percent
// - overload trip fault when thermal content reaches 100 percent
// - overload alarm stays until trip lockout is reset
// - stopped, line present, ABC expected, other rotation: alarm; start faults
// - stopped, line present, CBA expected, other rotation: alarm; start faults
// - low frequency alarm until in range or delay expires
// - high frequency alarm until valid or delay expires
// - stopped single phase setup, non single phase line: alarm; start faults
// - stopped three phase setup, single phase line: alarm; start faults
// - stopped, per pair low line alarm; start raises pair fault
// - stopped, per pair high line alarm; start raises pair fault
// - running phase loss alarm during delay, then phase loss fault
// - no line alarm when sync needed and no line seen
// - running overcurrent alarm during delay, then overcurrent fault
// - running undercurrent alarm during delay, then undercurrent fault
// - running imbalance alarm during delay, then imbalance fault
// - alarm code equals its associated fault code number
`timescale 1ns/1ps
`default_nettype none
`include "starter_alarm_consts.vh"
module starter_alarm_monitor #(
  parameter DELAY_WIDTH = 16,
  parameter THERM_WIDTH = 8
) (
  input wire clock,
  input wire rst_n,
  input wire clkEn,
  input wire running,
  input wire startCmd,
  input wire lineDetected,
  input wire rotationCba,
  input wire expectCba,
  input wire rotationCheck,
  input wire singlePhaseMode,
  input wire lineSinglePhase,
  input wire freqLow,
  input wire freqHigh,
  input wire [2:0] lowLinePair,
  input wire [2:0] highLinePair,
  input wire phaseLoss,
  input wire syncNeeded,
  input wire curOver,
  input wire curUnder,
  input wire curImbalance,
  input wire [THERM_WIDTH-1:0] thermalPct,
  input wire lockoutReset,
  input wire faultClear,
  input wire [DELAY_WIDTH-1:0] faultDelay,
  output reg [18:0] alarmVec_q,
  output reg [6:0] alarmCode_q,
  output reg faultActive_q,
  output reg [6:0] faultCode_q
);
  // ------------------------------------------------------------
  // input synchronisers (signals come from the front end pins)
  // ------------------------------------------------------------
  localparam NIN = 22;
  wire [NIN-1:0] rawIn;
  reg [NIN-1:0] meta_q;
  reg [NIN-1:0] sync_q;
  assign rawIn = {running, startCmd, lineDetected, rotationCba,
    freqLow, freqHigh, lowLinePair, highLinePair, phaseLoss,
    syncNeeded, curOver, curUnder, curImbalance, lockoutReset,
    faultClear, lineSinglePhase, expectCba, rotationCheck};
  always @(posedge clock) begin
    if (!rst_n) begin
      meta_q <= {NIN{1'b0}};
      sync_q <= {NIN{1'b0}};
    end else if (clkEn) begin
      meta_q <= rawIn;
      sync_q <= meta_q;
    end
  end
  wire sRun = sync_q[21];
  wire sStart = sync_q[20];
  wire sLine = sync_q[19];
  wire sRotCba = sync_q[18];
  wire sFreqLow = sync_q[17];
  wire sFreqHigh = sync_q[16];
  wire [2:0] sLowPair = sync_q[15:13];
  wire [2:0] sHighPair = sync_q[12:10];
  wire sPhLoss = sync_q[9];
  wire sSync = sync_q[8];
  wire sOver = sync_q[7];
  wire sUnder = sync_q[6];
  wire sImbal = sync_q[5];
  wire sLockRst = sync_q[4];
  wire sClear = sync_q[3];
  wire sLine1p = sync_q[2];
  wire sExpCba = sync_q[1];
  wire sRotChk = sync_q[0];
  wire stopped = ~sRun;
  // thermal value is from logic on this clock: no sync needed
  // ------------------------------------------------------------
  // configuration pin sync
  // ------------------------------------------------------------
  // mode pin is slow but still a pin: two stages like the rest
  reg modeMeta_q;
  reg modeSync_q;
  always @(posedge clock) begin
    if (!rst_n) begin
      modeMeta_q <= 1'b0;
      modeSync_q <= 1'b0;
    end else if (clkEn) begin
      modeMeta_q <= singlePhaseMode;
      modeSync_q <= modeMeta_q;
    end
  end
  wire sMode1p = modeSync_q;
  // ------------------------------------------------------------
  // thermal overload with lockout
  // ------------------------------------------------------------
  reg ovlLatch_q;
  reg tripLock_q;
  wire thermAlarm = thermalPct >= `THERM_ALARM_PCT;
  wire thermTrip = thermalPct >= `THERM_TRIP_PCT;
  always @(posedge clock) begin
    if (!rst_n) begin
      ovlLatch_q <= 1'b0;
      tripLock_q <= 1'b0;
    end else if (clkEn) begin
      // set wins over a simultaneous lockout reset
      if (thermTrip)
        tripLock_q <= 1'b1;
      else if (sLockRst)
        tripLock_q <= 1'b0;
      if (thermAlarm)
        ovlLatch_q <= 1'b1;
      else if (sLockRst && !tripLock_q)
        ovlLatch_q <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // stopped-state line checks, plus the no line check in any state
  // ------------------------------------------------------------
  wire rotAbcBad = stopped & sLine & sRotChk & ~sExpCba
    & (sRotCba != `ROT_ABC);
  wire rotCbaBad = stopped & sLine & sRotChk & sExpCba
    & (sRotCba == `ROT_ABC);
  // same latency as the line pins, so no false alarm on a mode change
  wire not1p = stopped & sLine & sMode1p & ~sLine1p;
  wire not3p = stopped & sLine & ~sMode1p & sLine1p;
  wire [2:0] lowA = {3{stopped}} & sLowPair;
  wire [2:0] highA = {3{stopped}} & sHighPair;
  wire noLine = sSync & ~sLine;
  // ------------------------------------------------------------
  // delay-qualified conditions, one timer each
  // ------------------------------------------------------------
  localparam ND = 6;
  wire [ND-1:0] dCond;
  wire [ND-1:0] dPend;
  wire [ND-1:0] dExp;
  assign dCond = {sFreqLow, sFreqHigh, sRun & sPhLoss, sRun & sOver,
    sRun & sUnder, sRun & sImbal};
  genvar g;
  generate
    for (g = 0; g < ND; g = g + 1) begin : gDelay
      fault_delay_timer #(
        .WIDTH(DELAY_WIDTH)
      ) uTimer (
        .clock(clock),
        .rst_n(rst_n),
        .enable(clkEn),
        .condition(dCond[g]),
        .delayCount(faultDelay),
        .pending(dPend[g]),
        .expired(dExp[g])
      );
    end
  endgenerate
  // ------------------------------------------------------------
  // alarm vector, one bit per code
  // ------------------------------------------------------------
  // bit order: 0 ovl,1 abc,2 cba,3 flo,4 fhi,5 n1p,6 n3p,7-9 low,
  // 10-12 high,13 ploss,14 noline,15 oc,16 uc,17 imb, 18 unused
  wire [18:0] alarmNow = {1'b0, dPend[0], dPend[1], dPend[2],
    noLine, dPend[3], highA, lowA, not3p, not1p,
    dPend[4], dPend[5], rotCbaBad, rotAbcBad, ovlLatch_q};
  // ------------------------------------------------------------
  // fault selection: thermal trip, expired delay or start command
  // ------------------------------------------------------------
  reg [6:0] faultSel;
  reg faultHit;
  always @* begin
    faultSel = `CODE_NONE;
    faultHit = 1'b1;
    if (thermTrip)
      faultSel = `CODE_OVERLOAD;
    else if (dExp[3])
      faultSel = `CODE_PHASE_LOSS;
    else if (dExp[2])
      faultSel = `CODE_OVER_CUR;
    else if (dExp[1])
      faultSel = `CODE_UNDER_CUR;
    else if (dExp[0])
      faultSel = `CODE_IMBALANCE;
    else if (dExp[5])
      faultSel = `CODE_FREQ_LOW;
    else if (dExp[4])
      faultSel = `CODE_FREQ_HIGH;
    else if (sStart && rotAbcBad)
      faultSel = `CODE_ROT_ABC;
    else if (sStart && rotCbaBad)
      faultSel = `CODE_ROT_CBA;
    else if (sStart && not1p)
      faultSel = `CODE_NOT_SINGLE;
    else if (sStart && not3p)
      faultSel = `CODE_NOT_THREE;
    else if (sStart && lowA[0])
      faultSel = `CODE_LOW_L12;
    else if (sStart && lowA[1])
      faultSel = `CODE_LOW_L12 + 7'h01;
    else if (sStart && lowA[2])
      faultSel = `CODE_LOW_L12 + 7'h02;
    else if (sStart && highA[0])
      faultSel = `CODE_HIGH_L12;
    else if (sStart && highA[1])
      faultSel = `CODE_HIGH_L12 + 7'h01;
    else if (sStart && highA[2])
      faultSel = `CODE_HIGH_L12 + 7'h02;
    else
      faultHit = 1'b0;
  end
  // ------------------------------------------------------------
  // reported alarm code: lowest active code shown
  // ------------------------------------------------------------
  reg [6:0] codeSel;
  always @* begin
    codeSel = `CODE_NONE;
    if (alarmNow[0])
      codeSel = `CODE_OVERLOAD;
    else if (alarmNow[1])
      codeSel = `CODE_ROT_ABC;
    else if (alarmNow[2])
      codeSel = `CODE_ROT_CBA;
    else if (alarmNow[3])
      codeSel = `CODE_FREQ_LOW;
    else if (alarmNow[4])
      codeSel = `CODE_FREQ_HIGH;
    else if (alarmNow[5])
      codeSel = `CODE_NOT_SINGLE;
    else if (alarmNow[6])
      codeSel = `CODE_NOT_THREE;
    else if (alarmNow[7])
      codeSel = `CODE_LOW_L12;
    else if (alarmNow[8])
      codeSel = `CODE_LOW_L12 + 7'h01;
    else if (alarmNow[9])
      codeSel = `CODE_LOW_L12 + 7'h02;
    else if (alarmNow[10])
      codeSel = `CODE_HIGH_L12;
    else if (alarmNow[11])
      codeSel = `CODE_HIGH_L12 + 7'h01;
    else if (alarmNow[12])
      codeSel = `CODE_HIGH_L12 + 7'h02;
    else if (alarmNow[13])
      codeSel = `CODE_PHASE_LOSS;
    else if (alarmNow[14])
      codeSel = `CODE_NO_LINE;
    else if (alarmNow[15])
      codeSel = `CODE_OVER_CUR;
    else if (alarmNow[16])
      codeSel = `CODE_UNDER_CUR;
    else if (alarmNow[17])
      codeSel = `CODE_IMBALANCE;
  end
  // ------------------------------------------------------------
  // output registers
  // ------------------------------------------------------------
  // first fault is kept; a new fault beats a clear in the same cycle
  always @(posedge clock) begin
    if (!rst_n) begin
      alarmVec_q <= 19'h00000;
      alarmCode_q <= `CODE_NONE;
      faultActive_q <= 1'b0;
      faultCode_q <= `CODE_NONE;
    end else if (clkEn) begin
      alarmVec_q <= alarmNow;
      alarmCode_q <= codeSel;
      if (faultHit && (!faultActive_q || sClear)) begin
        faultActive_q <= 1'b1;
        faultCode_q <= faultSel;
      end else if (sClear) begin
        faultActive_q <= 1'b0;
        faultCode_q <= `CODE_NONE;
      end
    end
  end
endmodule
`default_nettype wire

// [logic/starter_alarm_consts.vh]
`ifndef STARTER_ALARM_CONSTS_VH
`define STARTER_ALARM_CONSTS_VH
// ------------------------------------------------------------
// alarm / fault code numbers
// ------------------------------------------------------------
`define CODE_NONE 7'h00
`define CODE_OVERLOAD 7'h02
`define CODE_ROT_ABC 7'h0A
`define CODE_ROT_CBA 7'h0B
`define CODE_FREQ_LOW 7'h0C
`define CODE_FREQ_HIGH 7'h0D
`define CODE_NOT_SINGLE 7'h0E
`define CODE_NOT_THREE 7'h0F
`define CODE_LOW_L12 7'h15
`define CODE_HIGH_L12 7'h18
`define CODE_PHASE_LOSS 7'h1B
`define CODE_NO_LINE 7'h1C
`define CODE_OVER_CUR 7'h1F
`define CODE_UNDER_CUR 7'h22
`define CODE_IMBALANCE 7'h25
// ------------------------------------------------------------
// thermal levels in percent, reset values
// ------------------------------------------------------------
`define THERM_ALARM_PCT 8'h5A
`define THERM_TRIP_PCT 8'h64
`define DELAY_ZERO 16'h0000
`define ROT_ABC 1'b0
`endif

// [logic/fault_delay_timer.v]
`timescale 1ns/1ps
`default_nettype none
`include "starter_alarm_consts.vh"
module fault_delay_timer #(
  parameter WIDTH = 16
) (
  input wire clock,
  input wire rst_n,
  input wire enable,
  input wire condition,
  input wire [WIDTH-1:0] delayCount,
  output reg pending,
  output reg expired
);
  reg [WIDTH-1:0] count_q;
  // ------------------------------------------------------------
  // delay counter
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (!rst_n) begin
      count_q <= `DELAY_ZERO;
      pending <= 1'b0;
      expired <= 1'b0;
    end else if (enable) begin
      if (!condition) begin
        count_q <= `DELAY_ZERO;
        pending <= 1'b0;
        expired <= 1'b0;
      end else if (count_q >= delayCount) begin
        pending <= 1'b0;
        expired <= 1'b1;
      end else begin
        count_q <= count_q + 1'b1;
        pending <= 1'b1;
        expired <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/starter_alarm_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "starter_alarm_consts.vh"
// ------------------------------------------------------------
// alarm checker
// ------------------------------------------------------------
module starter_alarm_checker #(
  parameter DELAY_WIDTH = 16,
  parameter THERM_WIDTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic running,
  input wire logic lockoutReset,
  input wire logic faultClear,
  input wire logic [2:0] lowLinePair,
  input wire logic [THERM_WIDTH-1:0] thermalPct,
  input wire logic [DELAY_WIDTH-1:0] faultDelay,
  input wire logic [18:0] alarmVec_q,
  input wire logic [6:0] alarmCode_q,
  input wire logic [6:0] faultCode_q,
  input wire logic faultActive_q
);
  int cnt;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n || !clkEn);
  // four quiet cycles cover the sync pipeline
  sequence noLockRst; !lockoutReset [*4]; endsequence
  sequence noClear; !faultClear [*4]; endsequence
  always @(posedge clock) begin
    if (!rst_n) cnt <= 0;
    else if (clkEn) cnt <= alarmVec_q[15] ? cnt + 1 : 0;
  end
  ovl_set_a: assert property (
    thermalPct >= `THERM_ALARM_PCT |-> ##[1:3] alarmVec_q[0])
    else $error("overload alarm missing");
  ovl_trip_a: assert property (
    thermalPct >= `THERM_TRIP_PCT && !faultActive_q |-> ##[1:4]
    faultActive_q && faultCode_q == `CODE_OVERLOAD)
    else $error("overload trip missing");
  ovl_hold_a: assert property (
    noLockRst ##0 alarmVec_q[0] |=> alarmVec_q[0])
    else $error("overload alarm dropped");
  ovl_code_a: assert property (
    alarmVec_q[0] |-> alarmCode_q == `CODE_OVERLOAD)
    else $error("overload code wrong");
  fault_code_a: assert property (
    faultActive_q |-> faultCode_q != `CODE_NONE)
    else $error("fault without code");
  fault_hold_a: assert property (
    noClear ##0 faultActive_q |=> faultActive_q)
    else $error("fault dropped");
  stop_only_a: assert property (
    running [*5] |-> alarmVec_q[12:5] == 8'h00 && alarmVec_q[2:1] == 2'h0)
    else $error("stopped alarm while running");
  pair_low_a: assert property (
    (!running && $stable(lowLinePair)) [*5] |-> alarmVec_q[9:7] == lowLinePair)
    else $error("low pair alarm wrong");
  ovc_bound_a: assert property (
    cnt <= int'(faultDelay) + 4)
    else $error("overcurrent alarm outlived delay");
endmodule
bind starter_alarm_monitor starter_alarm_checker #(
  .DELAY_WIDTH(DELAY_WIDTH), .THERM_WIDTH(THERM_WIDTH)) u_chk (
  .clock(clock), .rst_n(rst_n), .clkEn(clkEn), .running(running),
  .lockoutReset(lockoutReset), .faultClear(faultClear),
  .lowLinePair(lowLinePair), .thermalPct(thermalPct),
  .faultDelay(faultDelay), .alarmVec_q(alarmVec_q),
  .alarmCode_q(alarmCode_q), .faultCode_q(faultCode_q),
  .faultActive_q(faultActive_q));
`default_nettype wire

// [testbench/front_end_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// measurement front end and start source
// ------------------------------------------------------------
module front_end_model (
  input wire logic clock,
  input wire logic [21:0] stim,
  input wire logic startReq,
  output logic [21:0] meas,
  output logic startCmd
);
  // levels launched just after the edge, held until changed
  always @(posedge clock) begin
    meas <= stim;
    startCmd <= startReq;
  end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// bench
// ------------------------------------------------------------
module tb_top;
  logic clock, rst_n, clkEn, startReq, startCmd, faultActive;
  logic [21:0] stim, meas, s;
  logic [7:0] thermal;
  logic [15:0] fdly;
  logic [18:0] alarmVec;
  logic [6:0] alarmCode, faultCode;
  int errors, checks_done;
  int cd[18] = '{2,10,11,12,13,14,15,21,22,23,24,25,26,27,28,31,34,37};
  logic [21:0] dl[6] = '{22'h8001,22'h20001,22'h40001,22'h80001,22'h80,
    22'h100};
  int dc[6] = '{27,31,34,37,12,13};
  logic [21:0] sl[6] = '{22'h16,22'h1A,22'h22,22'h42,22'h402,22'h4002};
  int sc[6] = '{10,11,14,15,22,26};
  initial begin
    clock = 0;
    forever #25 clock = ~clock;
  end
  front_end_model u_front_end_model(.clock(clock), .stim(stim),
    .startReq(startReq), .meas(meas), .startCmd(startCmd));
  starter_alarm_monitor u_starter_alarm_monitor(.clock(clock),
    .rst_n(rst_n), .clkEn(clkEn), .running(meas[0]), .startCmd(startCmd),
    .lineDetected(meas[1]), .rotationCba(meas[2]), .expectCba(meas[3]),
    .rotationCheck(meas[4]), .singlePhaseMode(meas[5]),
    .lineSinglePhase(meas[6]), .freqLow(meas[7]), .freqHigh(meas[8]),
    .lowLinePair(meas[11:9]), .highLinePair(meas[14:12]),
    .phaseLoss(meas[15]), .syncNeeded(meas[16]), .curOver(meas[17]),
    .curUnder(meas[18]), .curImbalance(meas[19]), .thermalPct(thermal),
    .lockoutReset(meas[20]), .faultClear(meas[21]), .faultDelay(fdly),
    .alarmVec_q(alarmVec), .alarmCode_q(alarmCode),
    .faultActive_q(faultActive), .faultCode_q(faultCode));
  function automatic logic [18:0] expv(input logic [21:0] s, input logic o);
    logic [18:0] v;
    v = 19'h00000;
    v[0] = o;
    v[1] = !s[0] && s[1] && s[4] && !s[3] && s[2];
    v[2] = !s[0] && s[1] && s[4] && s[3] && !s[2];
    v[4:3] = s[8:7];
    v[5] = !s[0] && s[5] && s[1] && !s[6];
    v[6] = !s[0] && !s[5] && s[1] && s[6];
    v[12:7] = s[0] ? 6'h00 : s[14:9];
    v[13] = s[0] && s[15];
    v[14] = s[16] && !s[1];
    v[17:15] = s[0] ? s[19:17] : 3'h0;
    return v;
  endfunction
  function automatic logic [6:0] expc(input logic [18:0] v);
    for (int i = 0; i < 18; i++) if (v[i]) return 7'(cd[i]);
    return 7'h00;
  endfunction
  task automatic cmpv(input logic [18:0] g, input logic [18:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t alarms %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmpc(input logic [6:0] g, input logic [6:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t code %0d expected %0d", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic put(input logic [21:0] v, input logic st);
    @(posedge clock);
    stim <= v;
    startReq <= st;
  endtask
  task automatic look(input logic [21:0] v, input logic o);
    @(negedge clock);
    cmpv(alarmVec, expv(v, o));
    cmpc(alarmCode, expc(expv(v, o)));
  endtask
  task automatic waitFault(input int code);
    int n;
    n = 0;
    while (faultActive !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    if (faultActive !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t fault never latched", $time);
      conclude;
    end
    cmpc(faultCode, 7'(code));
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    errors = 0;
    checks_done = 0;
    rst_n = 0;
    clkEn = 1;
    startReq = 0;
    stim = 0;
    thermal = 0;
    fdly = 16'h0100;
    void'($urandom(5));
    cyc(20);
    rst_n <= 1;
    cyc(6);
    look(0, 0);
    // long delay keeps random alarms short of expiry
    repeat (40) begin
      s = 22'($urandom) & 22'h0FFFFF;
      @(posedge clock);
      stim <= s;
      thermal <= 8'($urandom % 90);
      cyc(7);
      look(s, 0);
    end
    put(0, 0);
    thermal <= 8'h5A;
    cyc(5);
    look(0, 1);
    @(posedge clock) thermal <= 8'h59;
    cyc(5);
    look(0, 1);
    @(posedge clock) thermal <= 8'h64;
    waitFault(2);
    put(22'h300000, 0);
    thermal <= 8'h00;
    cyc(6);
    put(0, 0);
    cyc(6);
    look(0, 0);
    @(posedge clock) fdly <= 16'h000A;
    foreach (dl[i]) begin
      put(dl[i], 0);
      cyc(6);
      look(dl[i], 0);
      put(0, 0);
      cyc(20);
      @(negedge clock);
      cmpc(faultCode, 7'h00);
      put(dl[i], 0);
      waitFault(dc[i]);
      cyc(3);
      @(negedge clock);
      cmpv(alarmVec, 19'h00000);
      put(22'h200000, 0);
      cyc(6);
      put(0, 0);
      cyc(6);
    end
    foreach (sl[i]) begin
      put(sl[i], 0);
      cyc(6);
      look(sl[i], 0);
      put(sl[i], 1);
      waitFault(sc[i]);
      put(0, 0);
      cyc(6);
      put(22'h200000, 0);
      cyc(6);
      put(0, 0);
      cyc(6);
      @(negedge clock);
      cmpc(faultCode, 7'h00);
    end
    // clock enable low: all state frozen
    put(22'h000080, 0);
    clkEn <= 1'b0;
    cyc(8);
    @(negedge clock);
    cmpv(alarmVec, 19'h00000);
    @(posedge clock) clkEn <= 1'b1;
    cyc(7);
    look(22'h000080, 0);
    conclude;
  end
endmodule
`default_nettype wire
